//--- rtl/tsf_pkg.sv
/*
  Constants for the temperature sample FIFO and its interrupt enables:
  register offsets, bit positions, reset values and widths.
  Assumes the register port is driven by a serial-bus engine on clk_sys.
*/
// Operation
// - almost-full flag reaches alert only while enable bit 7 is set.
// - sample-ready flag reaches alert only while enable bit 6 is set.
// - falling-rate flag reaches alert only while enable bit 5 is set.
// - rising-rate flag reaches alert only while enable bit 4 is set.
// - low-alarm flag reaches alert only while enable bit 3 is set.
// - high-alarm flag reaches alert only while enable bit 2 is set.
// - six-bit write index, reset zero, advances per pushed sample, wraps.
// - six-bit read index, reset zero, advances per popped sample.
// - full FIFO drops new or oldest sample per overwrite policy bit.
// - six-bit lost sample count saturates at its maximum, never wraps.
// - seven-bit fill level reports stored samples, resets to zero.
// - read-only data port at 0x08 pops samples, resets to zero.
// - enable bits read and write, reset zero, bits 1 and 0 unused.
// - almost-full raised when free space equals threshold, threshold resets 0x1F.
// - self-clearing flush empties FIFO and zeroes both indices and fill level.
// - every status flag clears on status read; almost-full and ready also on data read with option.
// - power-on flag drives alert regardless of the enable register.
package tsf_pkg;
  localparam int        TSF_PTR_W        = 6;
  localparam int        TSF_LOST_W       = 6;
  localparam int        TSF_THR_W        = 6;

  localparam logic [7:0] TSF_ADDR_STATUS = 8'h00;
  localparam logic [7:0] TSF_ADDR_IRQ_EN = 8'h02;
  localparam logic [7:0] TSF_ADDR_WR_IDX = 8'h04;
  localparam logic [7:0] TSF_ADDR_RD_IDX = 8'h05;
  localparam logic [7:0] TSF_ADDR_LOST   = 8'h06;
  localparam logic [7:0] TSF_ADDR_FILL   = 8'h07;
  localparam logic [7:0] TSF_ADDR_DATA   = 8'h08;
  localparam logic [7:0] TSF_ADDR_CFG1   = 8'h09;
  localparam logic [7:0] TSF_ADDR_CFG2   = 8'h0a;

  // status and enable bit positions
  localparam int TSF_BIT_AFULL = 7;
  localparam int TSF_BIT_RDY   = 6;
  localparam int TSF_BIT_FALL  = 5;
  localparam int TSF_BIT_RISE  = 4;
  localparam int TSF_BIT_LOW   = 3;
  localparam int TSF_BIT_HIGH  = 2;
  localparam int TSF_BIT_PWR   = 0;

  // configuration 2 bit positions
  localparam int TSF_CFG_FLUSH   = 4;
  localparam int TSF_CFG_STATCLR = 3;
  localparam int TSF_CFG_AFTYPE  = 2;
  localparam int TSF_CFG_OVWR    = 1;

  localparam logic [7:0] TSF_STATUS_RST  = 8'h01;
  localparam logic [7:0] TSF_IRQ_EN_RST  = 8'h00;
  localparam logic [7:0] TSF_IRQ_EN_MASK = 8'hfc;
  localparam logic [7:0] TSF_CFG2_MASK   = 8'h0e;
  localparam logic [7:0] TSF_CFG2_RST    = 8'h00;
  localparam logic [5:0] TSF_THR_RST     = 6'h1f;
  localparam logic [7:0] TSF_DATA_RST    = 8'h00;
endpackage : tsf_pkg

//--- rtl/tsf_skid_buf.sv
/*
  Two-entry buffer with valid and ready on both sides.
  Assumes both sides run on clk_sys; out_data comes straight from a flop.
*/
`timescale 1ns/1ns
module tsf_skid_buf #(
  parameter int WIDTH = 8
) (
  input  wire logic             clk_sys,
  input  wire logic             rst_b,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  initial
  begin
    if (WIDTH < 1)
      $error("tsf_skid_buf: WIDTH must be at least 1");
  end

  typedef struct packed {
    logic [WIDTH-1:0] slot0;
    logic [WIDTH-1:0] slot1;
    logic [1:0]       used;
  } tsf_buf_state_t;

  tsf_buf_state_t state_ff;
  tsf_buf_state_t nxt_state;

  // ready looks only at occupancy, so no path runs from out_ready to in_ready
  assign in_ready  = (state_ff.used != 2'h2);
  assign out_valid = (state_ff.used != 2'h0);
  assign out_data  = state_ff.slot0;

  always_comb
  begin
    nxt_state = state_ff;
    if (out_valid && out_ready)
    begin
      nxt_state.slot0 = state_ff.slot1;
      nxt_state.used  = state_ff.used - 2'h1;
    end
    if (in_valid && in_ready)
    begin
      if (nxt_state.used == 2'h0)
        nxt_state.slot0 = in_data;
      else
        nxt_state.slot1 = in_data;
      nxt_state.used = nxt_state.used + 2'h1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      state_ff <= '0;
    else
      state_ff <= nxt_state;
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  AST_BUF_NO_LOSS: assert property (
    (in_valid && in_ready && !(out_valid && out_ready))
    |=> (state_ff.used == $past(state_ff.used) + 2'h1))
    else $error("buffer occupancy did not grow on accepted word");
endmodule : tsf_skid_buf

//--- rtl/tsf_sample_fifo.sv
/*
  Sample FIFO, status flags and interrupt enables of the temperature sensor.
  Assumes the serial-bus engine issues one-cycle reg_wr_en / reg_rd_en pulses
  on clk_sys, and that conversion logic delivers samples and events on clk_sys.
*/
`timescale 1ns/1ns
module tsf_sample_fifo
  import tsf_pkg::*;
#(
  parameter int PTR_W = TSF_PTR_W
) (
  input  wire logic       clk_sys,
  input  wire logic       rst_b,
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_wr_en,
  input  wire logic       reg_rd_en,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  output logic            reg_rvalid,
  input  wire logic       sample_valid,
  output logic            sample_ready,
  input  wire logic [7:0] sample_data,
  input  wire logic       rise_rate_evt,
  input  wire logic       fall_rate_evt,
  input  wire logic       low_alarm_evt,
  input  wire logic       high_alarm_evt,
  output logic            irq_alert
);
  localparam int DEPTH = 1 << PTR_W;
  localparam int CNT_W = PTR_W + 1;
  localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(DEPTH);

  initial
  begin
    if (PTR_W < 2 || PTR_W > TSF_THR_W)
      $error("tsf_sample_fifo: PTR_W must lie in 2..6");
  end

  typedef struct packed {
    logic [DEPTH-1:0][7:0]   mem;
    logic [PTR_W-1:0]        write_index;
    logic [PTR_W-1:0]        read_index;
    logic [TSF_LOST_W-1:0]   lost_sample_count;
    logic [CNT_W-1:0]        fill;
    logic [7:0]              data_port;
    logic [7:0]              status;
    logic [7:0]              irq_en;
    logic [TSF_THR_W-1:0]    afull_thr;
    logic [7:0]              cfg2;
    logic [7:0]              rdata;
    logic                    rvalid;
  } tsf_state_t;

  tsf_state_t state_ff;
  tsf_state_t nxt_state;

  logic       buf_valid;
  logic       buf_ready;
  logic [7:0] buf_data;
  logic       rd_status;
  logic       pop_req;
  logic       flush_req;
  logic       push_go;
  logic       pop_go;
  logic       fifo_full;
  logic       fifo_empty;
  logic       overwrite_policy;
  logic       clear_flags_on_data_read;

  tsf_skid_buf #(
    .WIDTH (8)
  ) u_in_buf (
    .clk_sys   (clk_sys),
    .rst_b     (rst_b),
    .in_valid  (sample_valid),
    .in_ready  (sample_ready),
    .in_data   (sample_data),
    .out_valid (buf_valid),
    .out_ready (buf_ready),
    .out_data  (buf_data)
  );

  assign rd_status  = reg_rd_en && (reg_addr == TSF_ADDR_STATUS);
  assign pop_req    = reg_rd_en && (reg_addr == TSF_ADDR_DATA);
  assign flush_req  = reg_wr_en && (reg_addr == TSF_ADDR_CFG2) && reg_wdata[TSF_CFG_FLUSH];
  assign fifo_full  = (state_ff.fill == FULL_CNT);
  assign fifo_empty = (state_ff.fill == '0);
  assign pop_go     = pop_req && !fifo_empty;
  // a push waits one cycle behind a host pop or flush; the buffer absorbs it
  assign buf_ready  = !pop_req && !flush_req;
  assign push_go    = buf_valid && buf_ready;
  assign overwrite_policy         = state_ff.cfg2[TSF_CFG_OVWR];
  assign clear_flags_on_data_read = state_ff.cfg2[TSF_CFG_STATCLR];

  always_comb
  begin
    logic [CNT_W-1:0] free_after;
    free_after = '0;
    nxt_state  = state_ff;
    nxt_state.rvalid = reg_rd_en;

    if (pop_go)
    begin
      nxt_state.data_port  = state_ff.mem[state_ff.read_index];
      nxt_state.read_index = state_ff.read_index + 1'b1;
      nxt_state.fill       = state_ff.fill - 1'b1;
    end

    if (push_go)
    begin
      if (!fifo_full || overwrite_policy)
      begin
        nxt_state.mem[state_ff.write_index] = buf_data;
        nxt_state.write_index = state_ff.write_index + 1'b1;
      end
      if (!fifo_full)
        nxt_state.fill = state_ff.fill + 1'b1;
      else
      begin
        if (overwrite_policy)
          nxt_state.read_index = state_ff.read_index + 1'b1;
        if (state_ff.lost_sample_count != '1)
          nxt_state.lost_sample_count = state_ff.lost_sample_count + 1'b1;
      end
    end

    if (flush_req)
    begin
      nxt_state.write_index = '0;
      nxt_state.read_index  = '0;
      nxt_state.fill        = '0;
    end

    // clears first, so an event in the same cycle wins
    if (rd_status)
      nxt_state.status = 8'h00;
    if (pop_req && clear_flags_on_data_read)
    begin
      nxt_state.status[TSF_BIT_AFULL] = 1'b0;
      nxt_state.status[TSF_BIT_RDY]   = 1'b0;
    end
    free_after = FULL_CNT - nxt_state.fill;
    if (push_go && (free_after == CNT_W'(state_ff.afull_thr)))
      nxt_state.status[TSF_BIT_AFULL] = 1'b1;
    if (push_go)
      nxt_state.status[TSF_BIT_RDY] = 1'b1;
    if (fall_rate_evt)
      nxt_state.status[TSF_BIT_FALL] = 1'b1;
    if (rise_rate_evt)
      nxt_state.status[TSF_BIT_RISE] = 1'b1;
    if (low_alarm_evt)
      nxt_state.status[TSF_BIT_LOW] = 1'b1;
    if (high_alarm_evt)
      nxt_state.status[TSF_BIT_HIGH] = 1'b1;

    if (reg_wr_en)
    begin
      case (reg_addr)
        TSF_ADDR_IRQ_EN: nxt_state.irq_en    = reg_wdata & TSF_IRQ_EN_MASK;
        TSF_ADDR_CFG1:   nxt_state.afull_thr = reg_wdata[TSF_THR_W-1:0];
        TSF_ADDR_CFG2:   nxt_state.cfg2      = reg_wdata & TSF_CFG2_MASK;
        default:         nxt_state.cfg2      = state_ff.cfg2;
      endcase
    end

    nxt_state.rdata = 8'h00;
    if (reg_rd_en)
    begin
      case (reg_addr)
        TSF_ADDR_STATUS: nxt_state.rdata = state_ff.status;
        TSF_ADDR_IRQ_EN: nxt_state.rdata = state_ff.irq_en;
        TSF_ADDR_WR_IDX: nxt_state.rdata = 8'(state_ff.write_index);
        TSF_ADDR_RD_IDX: nxt_state.rdata = 8'(state_ff.read_index);
        TSF_ADDR_LOST:   nxt_state.rdata = 8'(state_ff.lost_sample_count);
        TSF_ADDR_FILL:   nxt_state.rdata = 8'(state_ff.fill);
        TSF_ADDR_DATA:   nxt_state.rdata = nxt_state.data_port;
        TSF_ADDR_CFG1:   nxt_state.rdata = 8'(state_ff.afull_thr);
        TSF_ADDR_CFG2:   nxt_state.rdata = state_ff.cfg2;
        default:         nxt_state.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_ff           <= '0;
      state_ff.status    <= TSF_STATUS_RST;
      state_ff.irq_en    <= TSF_IRQ_EN_RST;
      state_ff.afull_thr <= TSF_THR_RST;
      state_ff.cfg2      <= TSF_CFG2_RST;
      state_ff.data_port <= TSF_DATA_RST;
    end
    else
      state_ff <= nxt_state;
  end

  // flag n passes only with enable bit n
  // power-on flag bypasses the enables; bits 1:0 of irq_en are always zero
  assign irq_alert  = |(state_ff.status & state_ff.irq_en)
                    | state_ff.status[TSF_BIT_PWR];
  assign reg_rdata  = state_ff.rdata;
  assign reg_rvalid = state_ff.rvalid;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  AST_AFULL_GATE: assert property (
    irq_alert == (state_ff.status[TSF_BIT_AFULL] && state_ff.irq_en[TSF_BIT_AFULL])
    || (irq_alert && (|(state_ff.status[6:0] & state_ff.irq_en[6:0])
    || state_ff.status[TSF_BIT_PWR])))
    else $error("almost-full enable gating wrong");
  AST_RDY_GATE: assert property (
    (state_ff.status[TSF_BIT_RDY] && state_ff.irq_en[TSF_BIT_RDY]) |-> irq_alert)
    else $error("sample-ready flag not forwarded");
  AST_FALL_GATE: assert property (
    (state_ff.status[TSF_BIT_FALL] && state_ff.irq_en[TSF_BIT_FALL]) |-> irq_alert)
    else $error("falling-rate flag not forwarded");
  AST_RISE_GATE: assert property (
    (state_ff.status[TSF_BIT_RISE] && state_ff.irq_en[TSF_BIT_RISE]) |-> irq_alert)
    else $error("rising-rate flag not forwarded");
  AST_LOW_GATE: assert property (
    (state_ff.status[TSF_BIT_LOW] && state_ff.irq_en[TSF_BIT_LOW]) |-> irq_alert)
    else $error("low-alarm flag not forwarded");
  AST_HIGH_GATE: assert property (
    (state_ff.status[TSF_BIT_HIGH] && state_ff.irq_en[TSF_BIT_HIGH]) |-> irq_alert)
    else $error("high-alarm flag not forwarded");
  AST_MASKED_QUIET: assert property (
    (state_ff.irq_en == 8'h00 && !state_ff.status[TSF_BIT_PWR]) |-> !irq_alert)
    else $error("alert raised with all enables clear");
  AST_PWR_ALERT: assert property (
    state_ff.status[TSF_BIT_PWR] |-> irq_alert)
    else $error("power-on flag did not drive alert");
  AST_WR_ADVANCE: assert property (
    (push_go && !fifo_full) |=> (state_ff.write_index == $past(state_ff.write_index) + 1'b1))
    else $error("write index did not advance on push");
  AST_RD_ADVANCE: assert property (
    (pop_go && !push_go) |=> (state_ff.read_index == $past(state_ff.read_index) + 1'b1)
    && (reg_rdata == state_ff.data_port))
    else $error("read index or data port wrong after pop");
  AST_DROP_NEW: assert property (
    (push_go && fifo_full && !overwrite_policy) |=> $stable(state_ff.write_index)
    && $stable(state_ff.read_index) && (state_ff.fill == FULL_CNT))
    else $error("full FIFO changed under keep-old policy");
  AST_LOST_SAT: assert property (
    (state_ff.lost_sample_count == '1) |=> (state_ff.lost_sample_count == '1))
    else $error("lost sample count wrapped");
  AST_FILL_BOUND: assert property (
    state_ff.fill <= FULL_CNT)
    else $error("fill level above depth");
  AST_EN_LOW_ZERO: assert property (
    (reg_wr_en && reg_addr == TSF_ADDR_IRQ_EN)
    |=> (state_ff.irq_en == ($past(reg_wdata) & TSF_IRQ_EN_MASK)))
    else $error("enable register write wrong");
  AST_FLUSH: assert property (
    flush_req |=> (state_ff.fill == '0) && (state_ff.write_index == '0)
    && (state_ff.read_index == '0) && !state_ff.cfg2[TSF_CFG_FLUSH])
    else $error("flush did not empty the FIFO");
  AST_STATUS_CLR: assert property (
    (rd_status && !push_go) |=> !state_ff.status[TSF_BIT_AFULL] && !state_ff.status[TSF_BIT_RDY])
    else $error("status read did not clear flags");

  // full-FIFO cases hinge on the overwrite policy, so both branches are watched
  AST_AFULL_SET: assert property (
    (push_go && !fifo_full
    && ((FULL_CNT - state_ff.fill) == (CNT_W'(state_ff.afull_thr) + 1'b1)))
    |=> state_ff.status[TSF_BIT_AFULL])
    else $error("almost-full flag not raised at threshold");
  AST_OVERWRITE: assert property (
    (push_go && fifo_full && overwrite_policy)
    |=> (state_ff.write_index == $past(state_ff.write_index) + 1'b1)
    && (state_ff.read_index == $past(state_ff.read_index) + 1'b1)
    && (state_ff.fill == FULL_CNT))
    else $error("overwrite did not drop the oldest sample");
  AST_LOST_INC: assert property (
    (push_go && fifo_full && (state_ff.lost_sample_count != '1))
    |=> (state_ff.lost_sample_count == $past(state_ff.lost_sample_count) + 1'b1))
    else $error("lost sample not counted");
  AST_FILL_INC: assert property (
    (push_go && !fifo_full)
    |=> (state_ff.fill == $past(state_ff.fill) + 1'b1) && state_ff.status[TSF_BIT_RDY])
    else $error("fill level or ready flag wrong after push");
  AST_DATA_CLR: assert property (
    (pop_req && clear_flags_on_data_read)
    |=> !state_ff.status[TSF_BIT_AFULL] && !state_ff.status[TSF_BIT_RDY])
    else $error("data read did not clear flags");
  AST_EMPTY_READ: assert property (
    (pop_req && fifo_empty)
    |=> $stable(state_ff.data_port) && $stable(state_ff.read_index))
    else $error("read of empty FIFO moved the data port");
  AST_RVALID: assert property (
    reg_rvalid == $past(reg_rd_en))
    else $error("read answer not one cycle after strobe");

  COV_AFULL_ALERT: cover property (
    state_ff.status[TSF_BIT_AFULL] && state_ff.irq_en[TSF_BIT_AFULL] && irq_alert);
  COV_OVERWRITE: cover property (push_go && fifo_full && overwrite_policy);
  COV_FLUSH_FULL: cover property (flush_req && fifo_full);
  COV_BACKPRESSURE: cover property (sample_valid && !sample_ready);
  COV_DATA_CLR: cover property (pop_go && clear_flags_on_data_read);
endmodule : tsf_sample_fifo

//--- test/tsf_host_model.sv
/*
  Host side of the register port: one-cycle write and read strobes.
  Assumes callers enter its tasks just after a falling edge of clk_sys.
*/
`timescale 1ns/1ns
module tsf_host_model (
  input  wire logic       clk_sys,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       reg_rvalid,
  output logic      [7:0] reg_addr,
  output logic            reg_wr_en,
  output logic            reg_rd_en,
  output logic      [7:0] reg_wdata
);
  initial
  begin
    reg_addr  = 8'h00;
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_wdata = 8'h00;
  end

  // idle lines show the inverse of the last value, so stale data cannot pass
  task wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr_en = 1'b1;
    @(negedge clk_sys);
    reg_wr_en = 1'b0;
    reg_addr  = ~a;
    reg_wdata = ~d;
    repeat (2) @(negedge clk_sys);
  endtask : wr

  task rd(input logic [7:0] a, output logic [7:0] d);
    int i;
    reg_addr  = a;
    reg_rd_en = 1'b1;
    @(negedge clk_sys);
    reg_rd_en = 1'b0;
    reg_addr  = ~a;
    i = 0;
    while (reg_rvalid !== 1'b1 && i < 8)
    begin
      @(negedge clk_sys);
      i++;
    end
    d = (i < 8) ? reg_rdata : 8'hxx;
    // one idle cycle, so a following read never re-raises the strobe in the same step
    @(negedge clk_sys);
  endtask : rd
endmodule : tsf_host_model

//--- test/tb_temp_sample_fifo_irq_enables.sv
/*
  Self-checking bench for the sample FIFO and interrupt enables.
  Assumes tsf_pkg and the design compiled first; a queue models the FIFO.
*/
`timescale 1ns/1ns
module tb_temp_sample_fifo_irq_enables
  import tsf_pkg::*;
;
  logic       clk_sys = 1'b0;
  logic       rst_b   = 1'b0;
  wire  [7:0] reg_addr;
  wire        reg_wr_en;
  wire        reg_rd_en;
  wire  [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic       reg_rvalid;
  logic       sample_valid;
  logic       sample_ready;
  logic [7:0] sample_data;
  logic [3:0] evt;
  logic       irq_alert;
  int         n_fail = 0;
  int         n_compared = 0;
  int         lost, wr_i, rd_i;
  logic       pol;
  logic [7:0] got, last;
  logic [7:0] q[$];
  int         bits[4] = '{4, 5, 3, 2};

  initial forever #4 clk_sys = ~clk_sys;

  tsf_host_model host (.clk_sys(clk_sys), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_wdata(reg_wdata));

  tsf_sample_fifo dut (.clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .sample_valid(sample_valid),
    .sample_ready(sample_ready), .sample_data(sample_data), .rise_rate_evt(evt[0]),
    .fall_rate_evt(evt[1]), .low_alarm_evt(evt[2]), .high_alarm_evt(evt[3]),
    .irq_alert(irq_alert));

  task results;
    if (n_fail == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : results

  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e)
    begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task rchk(input logic [7:0] a, input logic [7:0] e);
    host.rd(a, got);
    chk($sformatf("reg %h", a), e, got);
  endtask : rchk

  function automatic logic exp_alert(logic [7:0] st, logic [7:0] en);
    return (|(st[7:2] & en[7:2])) | st[0];
  endfunction : exp_alert

  task achk(input logic [7:0] st, input logic [7:0] en);
    chk("irq_alert", {7'h00, exp_alert(st, en)}, {7'h00, irq_alert});
  endtask : achk

  function automatic void model_push(logic [7:0] d);
    if (q.size() < 64)
    begin
      q.push_back(d);
      wr_i++;
    end
    else
    begin
      if (lost < 63)
        lost++;
      if (pol)
      begin
        void'(q.pop_front());
        q.push_back(d);
        wr_i++;
        rd_i++;
      end
    end
  endfunction : model_push

  // valid stays high across back-to-back samples; a stall simply holds the word
  task push(input int n);
    logic [7:0] d;
    sample_valid = 1'b1;
    repeat (n)
    begin
      d = 8'($urandom);
      sample_data = d;
      while (sample_ready !== 1'b1)
        @(negedge clk_sys);
      @(negedge clk_sys);
      model_push(d);
    end
    sample_valid = 1'b0;
    sample_data = ~sample_data;
    repeat (4) @(negedge clk_sys);
  endtask : push

  task pop;
    last = q.pop_front();
    rd_i++;
    rchk(TSF_ADDR_DATA, last);
  endtask : pop

  task idx_chk;
    rchk(TSF_ADDR_WR_IDX, 8'(wr_i % 64));
    rchk(TSF_ADDR_RD_IDX, 8'(rd_i % 64));
    rchk(TSF_ADDR_LOST, 8'(lost));
    rchk(TSF_ADDR_FILL, 8'(q.size()));
  endtask : idx_chk

  initial
  begin
    #400000;
    n_fail++;
    results();
  end

  initial
  begin
    void'($urandom(32'h4aae));
    evt = 4'h0;
    sample_valid = 1'b0;
    sample_data = 8'h00;
    pol = 1'b0;
    lost = 0;
    wr_i = 0;
    rd_i = 0;
    repeat (8) @(negedge clk_sys);
    rst_b = 1'b1;
    @(negedge clk_sys);
    achk(TSF_STATUS_RST, 8'h00);
    rchk(TSF_ADDR_STATUS, TSF_STATUS_RST);
    achk(8'h00, 8'h00);
    rchk(TSF_ADDR_IRQ_EN, TSF_IRQ_EN_RST);
    rchk(TSF_ADDR_DATA, TSF_DATA_RST);
    rchk(TSF_ADDR_CFG1, {2'b00, TSF_THR_RST});
    idx_chk();
    host.wr(TSF_ADDR_IRQ_EN, 8'hff);
    rchk(TSF_ADDR_IRQ_EN, TSF_IRQ_EN_MASK);
    host.wr(TSF_ADDR_IRQ_EN, 8'h00);
    rchk(8'h30, 8'h00);
    // one enable at a time, as a host in comparator autonomous mode must
    foreach (bits[i])
    begin
      evt[i] = 1'b1;
      @(negedge clk_sys);
      evt[i] = 1'b0;
      repeat (2) @(negedge clk_sys);
      achk(8'h01 << bits[i], 8'h00);
      host.wr(TSF_ADDR_IRQ_EN, 8'h01 << bits[i]);
      achk(8'h01 << bits[i], 8'h01 << bits[i]);
      host.wr(TSF_ADDR_IRQ_EN, 8'h00);
      rchk(TSF_ADDR_STATUS, 8'h01 << bits[i]);
    end
    push(1);
    achk(8'h40, 8'h00);
    host.wr(TSF_ADDR_IRQ_EN, 8'h40);
    achk(8'h40, 8'h40);
    host.wr(TSF_ADDR_IRQ_EN, 8'h00);
    rchk(TSF_ADDR_STATUS, 8'h40);
    push(32);
    achk(8'hc0, 8'h00);
    host.wr(TSF_ADDR_IRQ_EN, 8'h80);
    achk(8'hc0, 8'h80);
    rchk(TSF_ADDR_STATUS, 8'hc0);
    achk(8'h00, 8'h80);
    host.wr(TSF_ADDR_IRQ_EN, 8'h00);
    host.wr(TSF_ADDR_CFG1, 8'h00);
    rchk(TSF_ADDR_CFG1, 8'h00);
    push(31);
    idx_chk();
    push(70);
    idx_chk();
    pol = 1'b1;
    host.wr(TSF_ADDR_CFG2, 8'h02);
    push(3);
    idx_chk();
    repeat (64) pop();
    idx_chk();
    rchk(TSF_ADDR_DATA, last);
    host.wr(TSF_ADDR_CFG2, 8'h0a);
    rchk(TSF_ADDR_STATUS, 8'hc0);
    push(1);
    pop();
    rchk(TSF_ADDR_STATUS, 8'h00);
    push(5);
    // pops stall the buffer while samples stream in; no word may be lost
    fork
      push(4);
      repeat (4) pop();
    join
    idx_chk();
    pol = 1'b0;
    host.wr(TSF_ADDR_CFG2, 8'h10);
    q.delete();
    wr_i = 0;
    rd_i = 0;
    idx_chk();
    rchk(TSF_ADDR_CFG2, 8'h00);
    results();
  end
endmodule : tb_temp_sample_fifo_irq_enables
